// *** include/irq_flag_consts.svh ***
// Offsets, field positions and reset values of the sub-interrupt registers.
// Assumes a word-addressed Avalon-MM slave with 32-bit data.
`ifndef IRQ_FLAG_CONSTS_SVH
`define IRQ_FLAG_CONSTS_SVH

`define ADDR_W            4
`define OFS_STD_TIMER     4'h0
`define OFS_COMPACT_TIMER 4'h1
`define OFS_EEPROM_LV     4'h2
`define OFS_GLOBAL_CTRL   4'h3
`define OFS_EVT_STATUS    4'h4
`define OFS_EVT_MASK      4'h5
`define OFS_PEND_STATUS   4'h6

`define BIT_FLAG_HI       5
`define BIT_FLAG_LO       4
`define BIT_EN_HI         1
`define BIT_EN_LO         0
`define SUBREG_RW_MASK    8'h33
`define SUBREG_RESET      8'h00
`define GLOBAL_RESET      1'h0
`define EVT_RESET         6'h00
`define NUM_SRC           6

`endif

// *** include/irq_flag_pkg.sv ***
// Types shared by the sub-interrupt register block.
// Assumes the constants header is compiled alongside.
package irq_flag_pkg;
  typedef logic [7:0] subreg_t;
  typedef logic [5:0] src_vec_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK  = 2'h1
  } bus_state_t;
endpackage

// *** rtl/mf_irq_flag_enable_regs.sv ***
// Three sub-interrupt flag/enable registers with Avalon-MM access and a summary interrupt.
// Assumes source event pulses come from logic on core_clk.
//
// How it works
// - Standard timer A match request held in bit 5 of first register.
// - Bit 1 of first register enables standard timer A match interrupt.
// - Bit 0 of first register enables standard timer P match interrupt.
// - Compact timer A match request held in bit 5 of second register.
// - Bit 1 of second register enables compact timer A match interrupt.
// - Bit 1 of third register enables the data EEPROM interrupt.
// - Bit 0 of third register enables the low-voltage detector interrupt.
// - Flags set even when disabled; disabled flags raise no src_irq_req; the summary irq follows evt_status_reg and evt_mask_reg.
// - Global enable low blocks every source request on src_irq_req; the summary irq is not gated by it.
// - Any set request flag raises the wake request.
`include "irq_flag_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module mf_irq_flag_enable_regs
  import irq_flag_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Avalon-MM slave
  input  wire logic [`ADDR_W-1:0]  avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Source event pulses
  input  wire logic                std_timer_a_match_evt,
  input  wire logic                std_timer_p_match_evt,
  input  wire logic                compact_timer_a_match_evt,
  input  wire logic                compact_timer_p_match_evt,
  input  wire logic                eeprom_evt,
  input  wire logic                lowvolt_evt,
  // Requests out
  output logic      [5:0]          src_irq_req,
  output logic                     wake_req,
  output logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  subreg_t    std_timer_match_irq_ctrl_reg;
  subreg_t    compact_timer_match_irq_ctrl_reg;
  subreg_t    eeprom_lowvolt_irq_ctrl_reg;
  logic       global_irq_enable_reg;
  src_vec_t   evt_status_reg;
  src_vec_t   evt_mask_reg;
  bus_state_t bus_state_reg;

  src_vec_t   evt_in;
  src_vec_t   flags;
  src_vec_t   enables;
  logic       wr_take;
  logic       rd_take;
  logic       wr_lane0;
  logic       rd_sample;
  logic       sel_std;
  logic       sel_compact;
  logic       sel_eeprom;
  logic       sel_global;
  logic       sel_mask;
  logic       sel_status;
  logic       global_irq_enable_next;
  logic       wake_next;
  logic       irq_next;
  subreg_t    std_timer_match_irq_ctrl_next;
  subreg_t    compact_timer_match_irq_ctrl_next;
  subreg_t    eeprom_lowvolt_irq_ctrl_next;
  src_vec_t   evt_status_next;
  src_vec_t   evt_mask_next;
  logic [31:0] rd_mux;

  // Source order: std A, std P, compact A, compact P, eeprom, lowvolt
  assign evt_in = {lowvolt_evt, eeprom_evt, compact_timer_p_match_evt,
                   compact_timer_a_match_evt, std_timer_p_match_evt, std_timer_a_match_evt};

  assign flags = {eeprom_lowvolt_irq_ctrl_reg[`BIT_FLAG_LO],
                  eeprom_lowvolt_irq_ctrl_reg[`BIT_FLAG_HI],
                  compact_timer_match_irq_ctrl_reg[`BIT_FLAG_LO],
                  compact_timer_match_irq_ctrl_reg[`BIT_FLAG_HI],
                  std_timer_match_irq_ctrl_reg[`BIT_FLAG_LO],
                  std_timer_match_irq_ctrl_reg[`BIT_FLAG_HI]};

  assign enables = {eeprom_lowvolt_irq_ctrl_reg[`BIT_EN_LO],
                    eeprom_lowvolt_irq_ctrl_reg[`BIT_EN_HI],
                    compact_timer_match_irq_ctrl_reg[`BIT_EN_LO],
                    compact_timer_match_irq_ctrl_reg[`BIT_EN_HI],
                    std_timer_match_irq_ctrl_reg[`BIT_EN_LO],
                    std_timer_match_irq_ctrl_reg[`BIT_EN_HI]};

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second edge
  assign wr_take  = avs_write && bus_state_reg == BUS_ACK;
  assign rd_take  = avs_read && bus_state_reg == BUS_ACK;
  assign wr_lane0 = wr_take && avs_byteenable[0];
  assign rd_sample = avs_read && bus_state_reg == BUS_IDLE;

  // Address decode; the handshake qualifies each select where it is used
  assign sel_std     = avs_address == `OFS_STD_TIMER;
  assign sel_compact = avs_address == `OFS_COMPACT_TIMER;
  assign sel_eeprom  = avs_address == `OFS_EEPROM_LV;
  assign sel_global  = avs_address == `OFS_GLOBAL_CTRL;
  assign sel_mask    = avs_address == `OFS_EVT_MASK;
  assign sel_status  = avs_address == `OFS_EVT_STATUS;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_reg   <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg   <= BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_state_reg   <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_reg   <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the flag/enable registers
  // A write loads only the implemented bits, then an event forces its flag:
  // set beats a clearing write that lands in the same cycle
  always_comb begin
    std_timer_match_irq_ctrl_next = std_timer_match_irq_ctrl_reg;
    if (wr_lane0 && sel_std) begin
      std_timer_match_irq_ctrl_next = avs_writedata[7:0] & `SUBREG_RW_MASK;
    end
    if (evt_in[0]) begin
      std_timer_match_irq_ctrl_next[`BIT_FLAG_HI] = 1'b1;
    end
    if (evt_in[1]) begin
      std_timer_match_irq_ctrl_next[`BIT_FLAG_LO] = 1'b1;
    end
  end

  always_comb begin
    compact_timer_match_irq_ctrl_next = compact_timer_match_irq_ctrl_reg;
    if (wr_lane0 && sel_compact) begin
      compact_timer_match_irq_ctrl_next = avs_writedata[7:0] & `SUBREG_RW_MASK;
    end
    if (evt_in[2]) begin
      compact_timer_match_irq_ctrl_next[`BIT_FLAG_HI] = 1'b1;
    end
    if (evt_in[3]) begin
      compact_timer_match_irq_ctrl_next[`BIT_FLAG_LO] = 1'b1;
    end
  end

  always_comb begin
    eeprom_lowvolt_irq_ctrl_next = eeprom_lowvolt_irq_ctrl_reg;
    if (wr_lane0 && sel_eeprom) begin
      eeprom_lowvolt_irq_ctrl_next = avs_writedata[7:0] & `SUBREG_RW_MASK;
    end
    if (evt_in[4]) begin
      eeprom_lowvolt_irq_ctrl_next[`BIT_FLAG_HI] = 1'b1;
    end
    if (evt_in[5]) begin
      eeprom_lowvolt_irq_ctrl_next[`BIT_FLAG_LO] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag/enable registers; unimplemented bits never leave zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      std_timer_match_irq_ctrl_reg <= `SUBREG_RESET;
    end else begin
      std_timer_match_irq_ctrl_reg <= std_timer_match_irq_ctrl_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      compact_timer_match_irq_ctrl_reg <= `SUBREG_RESET;
    end else begin
      compact_timer_match_irq_ctrl_reg <= compact_timer_match_irq_ctrl_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eeprom_lowvolt_irq_ctrl_reg <= `SUBREG_RESET;
    end else begin
      eeprom_lowvolt_irq_ctrl_reg <= eeprom_lowvolt_irq_ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global enable, event mask and event status
  always_comb begin
    global_irq_enable_next = global_irq_enable_reg;
    evt_mask_next          = evt_mask_reg;
    if (wr_lane0 && sel_global) begin
      global_irq_enable_next = avs_writedata[0];
    end
    if (wr_lane0 && sel_mask) begin
      evt_mask_next = avs_writedata[5:0];
    end
  end

  // Clear on read drops only the bits that the read returned, so an event that
  // lands between fetch and answer stays pending; set wins over clear
  always_comb begin
    evt_status_next = evt_status_reg;
    if (rd_take && sel_status) begin
      evt_status_next = evt_status_reg & ~avs_readdata[5:0];
    end
    evt_status_next = evt_status_next | evt_in;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      global_irq_enable_reg <= `GLOBAL_RESET;
    end else begin
      global_irq_enable_reg <= global_irq_enable_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_mask_reg <= `EVT_RESET;
    end else begin
      evt_mask_reg <= evt_mask_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_status_reg <= `EVT_RESET;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; unmapped offsets and unimplemented bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `OFS_STD_TIMER:     rd_mux[7:0] = std_timer_match_irq_ctrl_reg;
      `OFS_COMPACT_TIMER: rd_mux[7:0] = compact_timer_match_irq_ctrl_reg;
      `OFS_EEPROM_LV:     rd_mux[7:0] = eeprom_lowvolt_irq_ctrl_reg;
      `OFS_GLOBAL_CTRL:   rd_mux[0]   = global_irq_enable_reg;
      `OFS_EVT_STATUS:    rd_mux[5:0] = evt_status_reg;
      `OFS_EVT_MASK:      rd_mux[5:0] = evt_mask_reg;
      `OFS_PEND_STATUS:   rd_mux[5:0] = flags & enables;
      default:            rd_mux      = 32'h0000_0000;
    endcase
  end

  // Fetched on the edge that sees the request, so it stands in the answer cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_sample) begin
      avs_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered; one cycle behind the flags
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_req
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          src_irq_req[g] <= 1'b0;
        end else begin
          src_irq_req[g] <= flags[g] & enables[g] & global_irq_enable_reg;
        end
      end
    end
  endgenerate

  // Summary levels, registered so each output leaves from a flip-flop
  always_comb begin
    wake_next = |flags;
    irq_next  = |(evt_status_reg & evt_mask_reg);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_req <= 1'b0;
      irq      <= 1'b0;
    end else begin
      wake_req <= wake_next;
      irq      <= irq_next;
    end
  end

endmodule // mf_irq_flag_enable_regs

`default_nettype wire

// *** tb/irq_flag_props.sv ***
// Checker for the sub-interrupt register block.
// Assumes it is bound to the block's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_props (
  // Clock, reset and bus
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Events and requests
  input wire logic        std_timer_a_match_evt,
  input wire logic        std_timer_p_match_evt,
  input wire logic        compact_timer_a_match_evt,
  input wire logic        compact_timer_p_match_evt,
  input wire logic        eeprom_evt,
  input wire logic        lowvolt_evt,
  input wire logic [5:0]  src_irq_req,
  input wire logic        wake_req
);
  logic evt_any;
  logic wr_act;
  assign evt_any = std_timer_a_match_evt | std_timer_p_match_evt | compact_timer_a_match_evt
                 | compact_timer_p_match_evt | eeprom_evt | lowvolt_evt;
  assign wr_act = avs_write & ~avs_waitrequest;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  AST_WAIT_IDLE: assert property (!(avs_read | avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_UPPER_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_UNUSED_BITS: assert property (avs_read && !avs_waitrequest && avs_address < 4'h3
    |-> (avs_readdata[7:0] & 8'hCC) == 8'h00)
    else $error("unimplemented bit reads one");
  AST_WAKE_EVT: assert property (evt_any |-> ##2 wake_req)
    else $error("event did not raise wake");
  AST_WAKE_HOLD: assert property (wake_req && !$past(evt_any) && !$past(wr_act) |=> wake_req)
    else $error("wake dropped without clearing write");
  AST_NO_WAKE: assert property (!wake_req && !$past(evt_any) && !$past(wr_act) |=> !wake_req)
    else $error("wake rose without a flag");
  AST_SRC_WAKE: assert property (|src_irq_req |-> wake_req)
    else $error("request without a set flag");
  AST_SRC_HOLD: assert property (src_irq_req[1] && !$past(wr_act) |=> src_irq_req[1])
    else $error("standard P request dropped");
endmodule // irq_flag_props
bind mf_irq_flag_enable_regs irq_flag_props props_u (.core_clk(core_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .std_timer_a_match_evt(std_timer_a_match_evt),
  .std_timer_p_match_evt(std_timer_p_match_evt), .compact_timer_a_match_evt(compact_timer_a_match_evt),
  .compact_timer_p_match_evt(compact_timer_p_match_evt), .eeprom_evt(eeprom_evt),
  .lowvolt_evt(lowvolt_evt), .src_irq_req(src_irq_req), .wake_req(wake_req));
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the sub-interrupt register block.
// Assumes the design, package and checker are compiled first.
`include "irq_flag_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb import irq_flag_pkg::*;;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  ben = 4'hF;
  logic [5:0]  evt = 6'h00;
  logic [31:0] rdata = 32'h0;
  logic [31:0] rdata_bus;
  logic        waitreq;
  logic [5:0]  src;
  logic        wake;
  logic        irq;
  int          err_count = 0;
  int          num_checks = 0;
  always #50 core_clk = ~core_clk;
  mf_irq_flag_enable_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata_bus),
    .avs_waitrequest(waitreq), .std_timer_a_match_evt(evt[0]), .std_timer_p_match_evt(evt[1]),
    .compact_timer_a_match_evt(evt[2]), .compact_timer_p_match_evt(evt[3]), .eeprom_evt(evt[4]),
    .lowvolt_evt(evt[5]), .src_irq_req(src), .wake_req(wake), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that samples waitrequest low; data taken there
  task automatic access(input logic w, input logic [3:0] a, input subreg_t d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    addr <= a;
    wdata <= {24'h0, d};
    ben <= be;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    if (!w) rdata = rdata_bus;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    evt <= 6'h01 << i;
    @(posedge core_clk);
    evt <= 6'h00;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  initial begin : main
    int i;
    logic [3:0] ra;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      access(1'b0, 4'(i), 8'h00, 4'hF);
      chk(rdata, 32'h0);
    end
    access(1'b1, `OFS_STD_TIMER, 8'hFF, 4'hF);
    access(1'b0, `OFS_STD_TIMER, 8'h00, 4'hF);
    chk(rdata, 32'h33);
    access(1'b1, `OFS_STD_TIMER, 8'h00, 4'hE);
    access(1'b0, `OFS_STD_TIMER, 8'h00, 4'hF);
    chk(rdata, 32'h33);
    access(1'b1, `OFS_STD_TIMER, 8'h00, 4'hF);
    tend("reset_access");
    for (i = 0; i < 6; i++) begin
      ra = 4'(i / 2);
      pulse(i);
      chk({31'h0, wake}, 32'h1);
      chk({26'h0, src}, 32'h0);
      access(1'b0, ra, 8'h00, 4'hF);
      chk(rdata, (i % 2) ? 32'h10 : 32'h20);
      access(1'b1, ra, 8'h00, 4'hF);
    end
    tend("flags");
    access(1'b1, `OFS_GLOBAL_CTRL, 8'h01, 4'hF);
    for (i = 0; i < 6; i++) begin
      ra = 4'(i / 2);
      access(1'b1, ra, (i % 2) ? 8'h01 : 8'h02, 4'hF);
      pulse(i);
      chk({26'h0, src}, 32'h1 << i);
      access(1'b1, `OFS_GLOBAL_CTRL, 8'h00, 4'hF);
      repeat (2) @(negedge core_clk);
      chk({26'h0, src}, 32'h0);
      access(1'b0, `OFS_PEND_STATUS, 8'h00, 4'hF);
      chk(rdata, 32'h1 << i);
      chk({31'h0, wake}, 32'h1);
      access(1'b1, `OFS_GLOBAL_CTRL, 8'h01, 4'hF);
      access(1'b1, ra, 8'h00, 4'hF);
    end
    tend("enables");
    chk({31'h0, irq}, 32'h0);
    access(1'b0, `OFS_EVT_STATUS, 8'h00, 4'hF);
    chk(rdata, 32'h3F);
    access(1'b0, `OFS_EVT_STATUS, 8'h00, 4'hF);
    chk(rdata, 32'h0);
    access(1'b1, `OFS_EVT_MASK, 8'h3F, 4'hF);
    pulse(3);
    chk({31'h0, irq}, 32'h1);
    access(1'b0, `OFS_EVT_STATUS, 8'h00, 4'hF);
    chk(rdata, 32'h08);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    tend("irq_status");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
